// >>> pin_select_pkg.sv
// constants for the shared pin function select block
// assumes a single 50 MHz core clock

package pin_select_pkg;

  localparam int unsigned CLK_PERIOD_NS = 20;

  // core supply settle time before the core reset may release
  localparam int unsigned SUPPLY_SETTLE_NS = 1000;
  localparam int unsigned SUPPLY_SETTLE_CYC =
    (SUPPLY_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

  // shared bidirectional pin indices
  localparam int unsigned NUM_SHARED_IO = 11;
  localparam int unsigned IO_WORD_CLK   = 0;
  localparam int unsigned IO_BIT_CLK    = 1;
  localparam int unsigned IO_AUDIO_DATA = 2;
  localparam int unsigned IO_M_DATA_OUT = 3;
  localparam int unsigned IO_M_DATA_IN  = 4;
  localparam int unsigned IO_M_CLK_OUT  = 5;
  localparam int unsigned IO_M_SEL_OUT  = 6;
  localparam int unsigned IO_S_DATA_OUT = 7;
  localparam int unsigned IO_S_DATA_IN  = 8;
  localparam int unsigned IO_S_CLK_IN   = 9;
  localparam int unsigned IO_UART_TX    = 10;

  // shared input-only pins follow the io pins in the role vector
  localparam int unsigned IN_S_SEL      = 11;
  localparam int unsigned IN_UART_RX    = 12;
  localparam int unsigned NUM_ROLES     = 13;
  localparam int unsigned ROLE_IDX_W    = 4;

  // reset value of the role vector: every shared pin general purpose
  localparam logic [12:0] ROLE_RESET     = 13'h0000;
  // serial roles chosen by the strap
  localparam logic [12:0] ROLE_STRAP_HI  = 13'h0078;
  localparam logic [12:0] ROLE_STRAP_LO  = 13'h0B80;

  typedef enum logic [1:0] {
    PWR_SLEEP  = 2'b00,
    PWR_SETTLE = 2'b01,
    PWR_STRAP  = 2'b11,
    PWR_RUN    = 2'b10
  } pwr_state_t;

endpackage

// >>> sync_2ff.sv
// two flip-flop level synchroniser, one per bit
// assumes inputs are asynchronous to clk_i

`timescale 1ns/1ps

module sync_2ff #(
  parameter int unsigned WIDTH = 1
) (
  input  wire logic             clk_i,
  input  wire logic             nrst_i,
  input  wire logic [WIDTH-1:0] async_i,
  output logic      [WIDTH-1:0] sync_o
);

  logic [WIDTH-1:0] meta_q;

  // clears low; the idle-high activity pin is only read once the sequencer is past sleep
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      meta_q <= '0;
      sync_o <= '0;
    end
    else
    begin
      meta_q <= async_i;
      sync_o <= meta_q;
    end
  end

endmodule

// >>> shared_pin_function_select.sv
// shared pin function select with core sleep and wake sequencing
// assumes pins arrive asynchronous; core-side signals share clk_i

`timescale 1ns/1ps

module shared_pin_function_select
  import pin_select_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SUPPLY_SETTLE_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  // pins
  input  wire logic                     hw_reset_n_i,
  input  wire logic                     strap_mode_i,
  input  wire logic                     core_activity_bidir_pin_i,
  output logic                          core_activity_bidir_pin_o,
  output logic                          core_activity_bidir_pin_oe_o,
  output logic                          core_power_indicator_pin_o,
  input  wire logic [NUM_SHARED_IO-1:0] shared_io_i,
  output logic      [NUM_SHARED_IO-1:0] shared_io_o,
  output logic      [NUM_SHARED_IO-1:0] shared_io_oe_o,
  input  wire logic                     slave_port_select_in,
  input  wire logic                     uart_receive_shared_pin,
  input  wire logic                     plain_input_one,
  input  wire logic                     plain_input_two,
  input  wire logic                     dedicated_io_pin_i,
  output logic                          dedicated_io_pin_o,
  output logic                          dedicated_io_pin_oe_o,
  // core power control
  output logic                          core_supply_on_o,
  output logic                          core_reset_n_o,
  output logic                          core_awake_o,
  // host command from the core's command decoder
  input  wire logic                     cmd_valid_i,
  input  wire logic [ROLE_IDX_W-1:0]    cmd_index_i,
  input  wire logic                     cmd_serial_i,
  output logic      [NUM_ROLES-1:0]     role_o,
  // core general purpose side
  input  wire logic [NUM_SHARED_IO-1:0] gpio_out_i,
  input  wire logic [NUM_SHARED_IO-1:0] gpio_oe_i,
  output logic      [NUM_SHARED_IO-1:0] gpio_in_o,
  output logic                          gpi_s_sel_o,
  output logic                          gpi_uart_rx_o,
  output logic                          gpi_one_o,
  output logic                          gpi_two_o,
  input  wire logic                     dedicated_io_pin_out_i,
  input  wire logic                     dedicated_io_pin_oe_i,
  output logic                          dedicated_io_pin_in_o,
  // master serial port engine
  input  wire logic                     master_port_select_out,
  input  wire logic                     master_port_clock_out,
  input  wire logic                     m_data_out_i,
  output logic                          master_port_data_in,
  // slave serial port engine
  output logic                          s_select_o,
  output logic                          s_clock_o,
  output logic                          s_data_in_o,
  input  wire logic                     slave_port_data_out,
  // uart and audio engines
  output logic                          uart_rx_o,
  input  wire logic                     uart_tx_i,
  input  wire logic                     audio_word_clock_out,
  input  wire logic                     audio_bit_clock_i,
  input  wire logic                     audio_data_i
);

  localparam int unsigned NUM_SYNC = NUM_SHARED_IO + 8;
  localparam int unsigned CNT_W    = $clog2(SETTLE_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(SETTLE_CYC - 1);

  // ---------------------------------------------------------------
  // pin synchronisers
  // ---------------------------------------------------------------
  logic [NUM_SYNC-1:0] pin_raw;
  logic [NUM_SYNC-1:0] pin_sync;

  assign pin_raw = {hw_reset_n_i, strap_mode_i, core_activity_bidir_pin_i,
                    slave_port_select_in, uart_receive_shared_pin,
                    plain_input_one, plain_input_two, dedicated_io_pin_i,
                    shared_io_i};

  sync_2ff #(
    .WIDTH (NUM_SYNC)
  ) u_pin_sync (
    .clk_i       (clk_i),
    .nrst_i      (nrst_i),
    .async_i     (pin_raw),
    .sync_o      (pin_sync)
  );

  logic [NUM_SHARED_IO-1:0] io_s;
  logic                     hw_rst_n_s;
  logic                     strap_s;
  logic                     act_s;
  logic                     ssel_s;
  logic                     rx_s;
  logic                     plain_input_one_s;
  logic                     plain_input_two_s;
  logic                     dedicated_io_pin_s;

  assign io_s       = pin_sync[NUM_SHARED_IO-1:0];
  assign dedicated_io_pin_s    = pin_sync[NUM_SHARED_IO];
  assign plain_input_two_s     = pin_sync[NUM_SHARED_IO+1];
  assign plain_input_one_s     = pin_sync[NUM_SHARED_IO+2];
  assign rx_s       = pin_sync[NUM_SHARED_IO+3];
  assign ssel_s     = pin_sync[NUM_SHARED_IO+4];
  assign act_s      = pin_sync[NUM_SHARED_IO+5];
  assign strap_s    = pin_sync[NUM_SHARED_IO+6];
  assign hw_rst_n_s = pin_sync[NUM_SHARED_IO+7];

  // ---------------------------------------------------------------
  // core power sequencer
  // ---------------------------------------------------------------
  pwr_state_t       state_q;
  pwr_state_t       state_d;
  logic [CNT_W-1:0] settle_q;
  logic             act_low;

  // the pin is only read once released; while driven low it reads our own drive
  assign act_low = (state_q != PWR_SLEEP) && !act_s;

  always_comb
  begin
    state_d = state_q;
    case (state_q)
      PWR_SLEEP:
      begin
        if (hw_rst_n_s)
          state_d = PWR_SETTLE;
      end
      PWR_SETTLE:
      begin
        // external rc keeps the activity pin low until the crystal is stable
        if (!hw_rst_n_s)
          state_d = PWR_SLEEP;
        else if (!act_low && settle_q == CNT_LAST)
          state_d = PWR_STRAP;
      end
      PWR_STRAP:
      begin
        if (!hw_rst_n_s)
          state_d = PWR_SLEEP;
        else if (act_low)
          state_d = PWR_SETTLE;
        else
          state_d = PWR_RUN;
      end
      PWR_RUN:
      begin
        if (!hw_rst_n_s)
          state_d = PWR_SLEEP;
        else if (act_low)
          state_d = PWR_SETTLE;
      end
      default:
      begin
        state_d = PWR_SLEEP;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      state_q <= PWR_SLEEP;
    else
      state_q <= state_d;
  end

  // settle counter restarts outside the settle state and whenever the activity pin reads low
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      settle_q <= '0;
    else if (state_q != PWR_SETTLE || act_low)
      settle_q <= '0;
    else if (settle_q != CNT_LAST)
      settle_q <= settle_q + CNT_W'(1);
  end

  // supply, reset and activity indicators
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      core_supply_on_o             <= 1'b0;
      core_reset_n_o               <= 1'b0;
      core_awake_o                 <= 1'b0;
      core_activity_bidir_pin_o    <= 1'b0;
      core_activity_bidir_pin_oe_o <= 1'b1;
      core_power_indicator_pin_o   <= 1'b0;
    end
    else
    begin
      core_supply_on_o             <= (state_d != PWR_SLEEP);
      core_reset_n_o               <= (state_d == PWR_STRAP) || (state_d == PWR_RUN);
      core_awake_o                 <= (state_d == PWR_RUN);
      core_activity_bidir_pin_o    <= 1'b0;
      core_activity_bidir_pin_oe_o <= (state_d == PWR_SLEEP);
      core_power_indicator_pin_o   <= (state_d != PWR_SLEEP);
    end
  end

  // ---------------------------------------------------------------
  // pin role vector: 1 = serial role, 0 = general purpose
  // ---------------------------------------------------------------
  logic [NUM_ROLES-1:0] role_q;
  logic                 run;

  assign run = (state_q == PWR_RUN);

  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
      role_q <= ROLE_RESET;
    else if (state_q == PWR_SLEEP || state_q == PWR_SETTLE)
      role_q <= ROLE_RESET;
    else if (state_q == PWR_STRAP)
      // strap read only here, on every pass through the strap state after settle
      role_q <= strap_s ? ROLE_STRAP_HI : ROLE_STRAP_LO;
    else if (cmd_valid_i && 32'(cmd_index_i) < NUM_ROLES)
      // out-of-range index ignored rather than wrapped
      role_q[cmd_index_i] <= cmd_serial_i;
  end

  assign role_o = role_q;

  // ---------------------------------------------------------------
  // serial-role drive per shared io pin
  // ---------------------------------------------------------------
  logic [NUM_SHARED_IO-1:0] ser_out;
  logic [NUM_SHARED_IO-1:0] ser_oe;

  always_comb
  begin
    ser_out = '0;
    ser_oe  = '0;
    ser_out[IO_WORD_CLK]   = audio_word_clock_out;
    ser_oe[IO_WORD_CLK]    = 1'b1;
    ser_out[IO_BIT_CLK]    = audio_bit_clock_i;
    ser_oe[IO_BIT_CLK]     = 1'b1;
    ser_out[IO_AUDIO_DATA] = audio_data_i;
    ser_oe[IO_AUDIO_DATA]  = 1'b1;
    ser_out[IO_M_SEL_OUT]  = master_port_select_out;
    ser_oe[IO_M_SEL_OUT]   = 1'b1;
    ser_out[IO_M_CLK_OUT]  = master_port_clock_out;
    ser_oe[IO_M_CLK_OUT]   = 1'b1;
    ser_out[IO_M_DATA_OUT] = m_data_out_i;
    ser_oe[IO_M_DATA_OUT]  = !master_port_select_out;
    ser_out[IO_S_DATA_OUT] = slave_port_data_out;
    // select that is not in its serial role counts as deselected
    ser_oe[IO_S_DATA_OUT]  = role_q[IN_S_SEL] && !ssel_s;
    ser_out[IO_UART_TX]    = uart_tx_i;
    ser_oe[IO_UART_TX]     = 1'b1;
  end

  // one registered driver per shared pin
  genvar gi;
  generate
    for (gi = 0; gi < NUM_SHARED_IO; gi++)
    begin : g_pin
      always_ff @(posedge clk_i or negedge nrst_i)
      begin
        if (!nrst_i)
        begin
          shared_io_o[gi]    <= 1'b0;
          shared_io_oe_o[gi] <= 1'b0;
        end
        else if (!run)
        begin
          shared_io_o[gi]    <= 1'b0;
          shared_io_oe_o[gi] <= 1'b0;
        end
        else if (role_q[gi])
        begin
          shared_io_o[gi]    <= ser_out[gi];
          shared_io_oe_o[gi] <= ser_oe[gi];
        end
        else
        begin
          shared_io_o[gi]    <= gpio_out_i[gi];
          shared_io_oe_o[gi] <= gpio_oe_i[gi];
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------
  // dedicated pin and core-side inputs
  // ---------------------------------------------------------------
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      dedicated_io_pin_o    <= 1'b0;
      dedicated_io_pin_oe_o <= 1'b0;
    end
    else
    begin
      dedicated_io_pin_o    <= run && dedicated_io_pin_out_i;
      dedicated_io_pin_oe_o <= run && dedicated_io_pin_oe_i;
    end
  end

  // serial engines see idle levels while their pins are general purpose
  always_ff @(posedge clk_i or negedge nrst_i)
  begin
    if (!nrst_i)
    begin
      gpio_in_o           <= '0;
      gpi_s_sel_o         <= 1'b0;
      gpi_uart_rx_o       <= 1'b0;
      gpi_one_o           <= 1'b0;
      gpi_two_o           <= 1'b0;
      dedicated_io_pin_in_o          <= 1'b0;
      master_port_data_in <= 1'b0;
      s_select_o          <= 1'b1;
      s_clock_o           <= 1'b0;
      s_data_in_o         <= 1'b0;
      uart_rx_o           <= 1'b1;
    end
    else
    begin
      gpio_in_o           <= io_s;
      gpi_s_sel_o         <= ssel_s;
      gpi_uart_rx_o       <= rx_s;
      gpi_one_o           <= plain_input_one_s;
      gpi_two_o           <= plain_input_two_s;
      dedicated_io_pin_in_o          <= dedicated_io_pin_s;
      master_port_data_in <= role_q[IO_M_DATA_IN] && io_s[IO_M_DATA_IN];
      s_select_o          <= !role_q[IN_S_SEL] || ssel_s;
      s_clock_o           <= role_q[IO_S_CLK_IN] && io_s[IO_S_CLK_IN];
      s_data_in_o         <= role_q[IO_S_DATA_IN] && io_s[IO_S_DATA_IN];
      uart_rx_o           <= !role_q[IN_UART_RX] || rx_s;
    end
  end

endmodule

// >>> pin_select_props.sv
// assertions on the ports of the shared pin function select block
// assumes one clock domain with an asynchronous active low reset
`timescale 1ns/1ps

module pin_select_props
  import pin_select_pkg::*;
#(
  parameter int unsigned SETTLE_CYC = SUPPLY_SETTLE_CYC
) (
  input  wire logic                     clk_i,
  input  wire logic                     nrst_i,
  input  wire logic                     hw_reset_n_i,
  input  wire logic                     strap_mode_i,
  input  wire logic                     core_activity_bidir_pin_i,
  input  wire logic                     core_activity_bidir_pin_o,
  input  wire logic                     core_activity_bidir_pin_oe_o,
  input  wire logic                     core_power_indicator_pin_o,
  input  wire logic [NUM_SHARED_IO-1:0] shared_io_o,
  input  wire logic [NUM_SHARED_IO-1:0] shared_io_oe_o,
  input  wire logic                     slave_port_select_in,
  input  wire logic                     core_supply_on_o,
  input  wire logic                     core_reset_n_o,
  input  wire logic                     core_awake_o,
  input  wire logic [NUM_ROLES-1:0]     role_o,
  input  wire logic                     master_port_select_out,
  input  wire logic                     audio_word_clock_out
);
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (!nrst_i);

  // pin registers only follow roles while running, so both cycles must be run
  sequence hw_rise;
    $rose(hw_reset_n_i) && !core_supply_on_o;
  endsequence
  sequence run_step_m;
    core_awake_o && role_o[IO_M_DATA_OUT] ##1 core_awake_o;
  endsequence
  sequence run_step_a;
    core_awake_o && role_o[IO_WORD_CLK] ##1 core_awake_o;
  endsequence

  indicator_follow_a: assert property (core_power_indicator_pin_o == core_supply_on_o)
    else $error("power indicator differs from core supply");
  activity_release_a: assert property (
    core_activity_bidir_pin_oe_o == !core_supply_on_o && !core_activity_bidir_pin_o)
    else $error("activity pin drive wrong for supply state");
  sleep_entry_a: assert property ($fell(hw_reset_n_i) |-> ##[1:6] !core_supply_on_o)
    else $error("core supply still on after hardware reset");
  wake_entry_a: assert property (hw_rise |-> ##[2:5] core_supply_on_o)
    else $error("core supply not on after hardware reset release");
  awake_order_a: assert property (
    $rose(core_awake_o) |-> $past(core_reset_n_o) && core_supply_on_o)
    else $error("core awake before init");
  strap_roles_a: assert property (
    $rose(core_awake_o) |-> role_o == (strap_mode_i ? ROLE_STRAP_HI : ROLE_STRAP_LO))
    else $error("roles do not match strap");
  general_pre_a: assert property (
    !core_reset_n_o && !$past(core_reset_n_o) |-> role_o == ROLE_RESET)
    else $error("serial role before strap decision");
  master_float_a: assert property (
    run_step_m |-> shared_io_oe_o[IO_M_DATA_OUT] == !$past(master_port_select_out))
    else $error("master data out drive wrong for select");
  slave_float_a: assert property (
    (role_o[IO_S_DATA_OUT] && slave_port_select_in)[*4] |-> !shared_io_oe_o[IO_S_DATA_OUT])
    else $error("slave data out driven while deselected");
  audio_drive_a: assert property (run_step_a |-> shared_io_oe_o[IO_WORD_CLK] &&
    shared_io_o[IO_WORD_CLK] == $past(audio_word_clock_out))
    else $error("word clock not driven out");
  act_reset_a: assert property (
    $fell(core_activity_bidir_pin_i) && core_awake_o |-> ##[1:5] !core_reset_n_o)
    else $error("core not reset by low activity pin");
endmodule

bind shared_pin_function_select pin_select_props #(.SETTLE_CYC(SETTLE_CYC)) props_u (
  .clk_i(clk_i), .nrst_i(nrst_i), .hw_reset_n_i(hw_reset_n_i), .strap_mode_i(strap_mode_i),
  .core_activity_bidir_pin_i(core_activity_bidir_pin_i),
  .core_activity_bidir_pin_o(core_activity_bidir_pin_o),
  .core_activity_bidir_pin_oe_o(core_activity_bidir_pin_oe_o),
  .core_power_indicator_pin_o(core_power_indicator_pin_o), .shared_io_o(shared_io_o),
  .shared_io_oe_o(shared_io_oe_o), .slave_port_select_in(slave_port_select_in),
  .core_supply_on_o(core_supply_on_o), .core_reset_n_o(core_reset_n_o),
  .core_awake_o(core_awake_o), .role_o(role_o), .master_port_select_out(master_port_select_out),
  .audio_word_clock_out(audio_word_clock_out));

// >>> far_side_model.sv
// board side model: activity pin delay network and a serial flash rom
// assumes the bench resolves the shared pins and hands in their levels
`timescale 1ns/1ps

module far_side_model #(
  parameter int unsigned HOLD_CYC = 4
) (
  input  wire logic clk_i,
  input  wire logic act_out_i,
  input  wire logic act_oe_i,
  input  wire logic pull_low_i,
  input  wire logic rom_sel_i,
  input  wire logic rom_clk_i,
  output logic      act_pin_o,
  output logic      rom_data_o
);
  int unsigned hold_q = 0;
  logic [7:0]  rom_q = 8'hA5;
  logic        rom_clk_q = 1'b0;

  // rc network keeps the pin low a while after release, crystal settle time
  always @(posedge clk_i)
    hold_q <= act_oe_i ? HOLD_CYC : ((hold_q != 0) ? hold_q - 1 : 0);
  // pull-up when released; an outside agent may pull it low
  assign act_pin_o = act_oe_i ? act_out_i : !(pull_low_i || hold_q != 0);

  // deselected line wanders so a stale value is never seen as data
  always @(posedge clk_i)
  begin
    rom_clk_q <= rom_clk_i;
    if (!rom_sel_i && rom_clk_i && !rom_clk_q)
      rom_q <= {rom_q[6:0], rom_q[7]};
    else if (rom_sel_i)
      rom_q[7] <= !rom_q[7];
  end
  assign rom_data_o = rom_q[7];
endmodule

// >>> tb.sv
// self-checking bench for the shared pin function select block
// assumes the checker is bound in; inputs change on the falling edge
`timescale 1ns/1ps

module tb;
  import pin_select_pkg::*;
  int          mismatches = 0;
  int          total_checks = 0;
  int          cycles = 0;
  logic        clk_i = 1'b0;
  logic        nrst_i = 1'b0;
  logic        hw = 1'b0;
  logic        strap = 1'b1;
  logic        pull_low = 1'b0;
  logic        s_sel = 1'b1;
  logic        urx = 1'b1;
  logic [1:0]  plain = 2'h0;
  logic        cmd_v = 1'b0;
  logic        cmd_s = 1'b0;
  logic [3:0]  cmd_idx = 4'h0;
  logic [7:0]  eng = 8'h00;
  logic [10:0] gp_oe = 11'h3F8;
  logic [1:0]  dio_drv = 2'h0;
  logic [12:0] exp_role;
  wire         act_o, act_oe, act_pin, pwr, rom, dio_o, dio_oe, sup, crst_n, awake;
  wire         s_sel_o, rx_o, g1, g2, m_din, dio_in;
  wire  [10:0] io_o, io_oe, pins;
  wire  [12:0] role;

  // undriven pins see a changing level, pin 4 comes from the rom
  assign pins = (io_oe & io_o) | (~io_oe & {eng[5:0], rom, eng[3:0]});

  shared_pin_function_select #(.SETTLE_CYC(2)) dut (
    .clk_i(clk_i), .nrst_i(nrst_i), .hw_reset_n_i(hw), .strap_mode_i(strap),
    .core_activity_bidir_pin_i(act_pin), .core_activity_bidir_pin_o(act_o),
    .core_activity_bidir_pin_oe_o(act_oe), .core_power_indicator_pin_o(pwr),
    .shared_io_i(pins), .shared_io_o(io_o), .shared_io_oe_o(io_oe),
    .slave_port_select_in(s_sel), .uart_receive_shared_pin(urx),
    .plain_input_one(plain[0]), .plain_input_two(plain[1]),
    .dedicated_io_pin_i(dio_oe ? dio_o : 1'b1), .dedicated_io_pin_o(dio_o),
    .dedicated_io_pin_oe_o(dio_oe), .core_supply_on_o(sup), .core_reset_n_o(crst_n),
    .core_awake_o(awake), .cmd_valid_i(cmd_v), .cmd_index_i(cmd_idx), .cmd_serial_i(cmd_s),
    .role_o(role), .gpio_out_i({eng[2:0], eng}), .gpio_oe_i(gp_oe), .gpio_in_o(),
    .gpi_s_sel_o(), .gpi_uart_rx_o(), .gpi_one_o(g1), .gpi_two_o(g2),
    .dedicated_io_pin_out_i(dio_drv[0]), .dedicated_io_pin_oe_i(dio_drv[1]), .dedicated_io_pin_in_o(dio_in),
    .master_port_select_out(eng[3]), .master_port_clock_out(eng[0]), .m_data_out_i(eng[1]),
    .master_port_data_in(m_din), .s_select_o(s_sel_o), .s_clock_o(), .s_data_in_o(),
    .slave_port_data_out(eng[2]), .uart_rx_o(rx_o), .uart_tx_i(eng[4]),
    .audio_word_clock_out(eng[5]), .audio_bit_clock_i(eng[0]), .audio_data_i(eng[6]));

  far_side_model #(.HOLD_CYC(4)) far (
    .clk_i(clk_i), .act_out_i(act_o), .act_oe_i(act_oe), .pull_low_i(pull_low),
    .rom_sel_i(pins[IO_M_SEL_OUT]), .rom_clk_i(pins[IO_M_CLK_OUT]),
    .act_pin_o(act_pin), .rom_data_o(rom));

  always #10 clk_i = ~clk_i;
  always @(negedge clk_i) eng <= eng + 8'h01;
  // whole run needs about a hundred cycles
  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 3000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end

  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", total_checks, mismatches);
    if (mismatches == 0 && total_checks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      mismatches++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic cyc(input int n);
    repeat (n) @(negedge clk_i);
  endtask

  task automatic wait_awake();
    int k;
    k = 0;
    while (awake !== 1'b1 && k < 200)
    begin
      @(negedge clk_i);
      k++;
    end
    chk("awake", awake, 16'h1);
  endtask

  task automatic t_wake(input logic s, input logic [12:0] mask);
    strap = s;
    hw = 1'b1;
    wait_awake();
    chk("role", role, mask);
    chk("crst_n", crst_n, 16'h1);
    chk("power", pwr, 16'h1);
    chk("act_oe", act_oe, 16'h0);
    cyc(2);
  endtask

  task automatic t_master();
    t_wake(1'b1, ROLE_STRAP_HI);
    chk("m_pins", io_oe[6:4], 16'h6);
    chk("s_pins", io_oe[9:7], {13'h0, gp_oe[9:7]});
    $display("test master wake done");
  endtask

  task automatic t_cmd();
    logic [3:0] idx [7] = '{4'h0, 4'h1, 4'h2, 4'hA, 4'hC, 4'hD, 4'h3};
    logic       ser [7] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0};
    exp_role = ROLE_STRAP_HI;
    cmd_v = 1'b1;
    // back to back, one per cycle; index past the roles must be ignored
    foreach (idx[i])
    begin
      cmd_idx = idx[i];
      cmd_s = ser[i];
      if (idx[i] < NUM_ROLES)
        exp_role[idx[i]] = ser[i];
      @(negedge clk_i);
    end
    cmd_v = 1'b0;
    cyc(2);
    chk("role", role, exp_role);
    chk("audio_oe", io_oe[2:0], 16'h7);
    chk("tx_oe", io_oe[10], 16'h1);
    chk("gp_oe3", io_oe[3], gp_oe[3]);
    urx = 1'b0;
    plain = 2'h2;
    cyc(4);
    chk("uart_rx", rx_o, 16'h0);
    chk("plain", {g2, g1}, 16'h2);
    // dedicated pin driven low by the core, read back through the pin
    dio_drv = 2'h2;
    cyc(5);
    chk("dio", {dio_oe, dio_o, dio_in}, 16'h4);
    dio_drv = 2'h0;
    strap = 1'b0;
    cyc(6);
    chk("role", role, exp_role);
    $display("test commands done");
  endtask

  task automatic t_act();
    pull_low = 1'b1;
    cyc(8);
    chk("crst_n", crst_n, 16'h0);
    chk("awake", awake, 16'h0);
    pull_low = 1'b0;
    wait_awake();
    chk("role", role, ROLE_STRAP_LO);
    $display("test activity reset done");
  endtask

  task automatic t_sleep();
    hw = 1'b0;
    cyc(8);
    chk("supply", sup, 16'h0);
    chk("power", pwr, 16'h0);
    chk("act_oe", act_oe, 16'h1);
    chk("act_o", act_o, 16'h0);
    chk("role", role, ROLE_RESET);
    $display("test sleep done");
  endtask

  task automatic t_slave();
    t_wake(1'b0, ROLE_STRAP_LO);
    s_sel = 1'b0;
    cyc(4);
    chk("s_select", s_sel_o, 16'h0);
    chk("s_pins", io_oe[9:8], 16'h0);
    chk("m_pins", io_oe[6:3], {12'h0, gp_oe[6:3]});
    chk("s_out_oe", io_oe[7], 16'h1);
    chk("m_din", m_din, 16'h0);
    s_sel = 1'b1;
    cyc(4);
    chk("s_out_oe", io_oe[7], 16'h0);
    $display("test slave wake done");
  endtask

  initial
  begin
    cyc(9);
    chk("act_oe", act_oe, 16'h1);
    chk("power", pwr, 16'h0);
    chk("supply", sup, 16'h0);
    chk("io_oe", io_oe, 16'h0);
    chk("dio_oe", dio_oe, 16'h0);
    $display("test reset done");
    cyc(1);
    nrst_i = 1'b1;
    cyc(2);
    t_master();
    t_cmd();
    t_act();
    t_sleep();
    t_slave();
    tally_and_finish();
  end
endmodule
